/* File: lcd_port_cfg.svh */
// constants for the serial command port and pixel bus capture
`ifndef LCD_PORT_CFG_SVH
`define LCD_PORT_CFG_SVH

`define START_PATTERN 5'h0e
`define STRAP_SPI_MODE 3'h2
`define DUMMY_READ_BYTES 3'h5
`define IDX_RGB_CTRL 8'h0c
`define RGB_WIDTH_LSB 0
`define RGB_WIDTH_MSB 1
`define WIDTH_RESET 2'h0
`define INDEX_RESET 8'h00
`define STATUS_RESET 8'h00

`define REG_STATUS_WORD 4'h0
`define REG_PORT_INFO 4'h1
`define REG_PIXEL 4'h2
`define REG_LINE_COUNT 4'h3
`define REG_PAR_WORD 4'h4

`endif

/* File: lcd_port_pkg.sv */
// types shared by the serial port and pixel capture logic
package lcd_port_pkg;
    typedef enum logic [1:0] {
        ST_START  = 2'b00,
        ST_DATA   = 2'b01,
        ST_IGNORE = 2'b10
    } spi_state_t;

    typedef enum logic [1:0] {
        BUS_W18 = 2'b00,
        BUS_W16 = 2'b01,
        BUS_W6  = 2'b10,
        BUS_BAD = 2'b11
    } pix_width_t;
endpackage

/* File: regfile_if.sv */
// write and read port between the serial engine and the register memory
`timescale 1ns/10ps
`default_nettype none
interface regfile_if;
    logic wr_en;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [7:0] raddr;
    logic [15:0] rdata;
    modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
    modport mem (input wr_en, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: reg_memory.sv */
// 256 x 16 control register store, registered read data
`timescale 1ns/10ps
`default_nettype none
module reg_memory (
    input wire logic clk,
    input wire logic rst_n,
    regfile_if.mem port
);
    logic [15:0] store [0:255];

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.waddr] <= port.wdata;
        end
    end

    // write-through so a read just after a write sees the new word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.rdata <= 16'h0000;
        end else if (port.wr_en && port.waddr == port.raddr) begin
            port.rdata <= port.wdata;
        end else begin
            port.rdata <= store[port.raddr];
        end
    end
endmodule // reg_memory
`default_nettype wire

/* File: lcd_host_port.sv */
// serial command port and RGB pixel bus capture of the display module
//
// Design decisions made here: the address map and strobed register access.
`include "lcd_port_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_CLOCK,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_EN,
    input wire logic [3:0] INTERFACE_MODE_STRAPS,
    input wire logic IDENTITY_STRAP_BIT,
    input wire logic PIXEL_CLOCK,
    input wire logic PIXEL_ENABLE,
    input wire logic LINE_SYNC,
    input wire logic FRAME_SYNC,
    input wire logic [17:0] PIXEL_DATA_PINS,
    output logic [17:0] PIXEL_WORD,
    output logic PIXEL_VALID,
    output var lcd_port_pkg::pix_width_t PIXEL_BUS_WIDTH_SEL,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);
    import lcd_port_pkg::*;

    // 16-bit bus: r5 on 17:13, g6 b5 on 11:1; widened by repeating msbs
    function automatic logic [17:0] widen16(input logic [17:0] b);
        widen16 = {b[17:13], b[17], b[11:6], b[5:1], b[5]};
    endfunction

    logic rst_m, rst_n;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // all pins except REG_ADDR, REG_WDATA, REG_WR and REG_RD cross into CLK through two flops before use
    logic cs_m, cs_s, scl_m, scl_s, scl_d, sdi_m, sdi_s, id_m, id_s;
    logic [3:0] im_m, im_s;
    logic pclk_m, pclk_s, pclk_d, pen_m, pen_s;
    logic hs_m, hs_s, hs_d, vs_m, vs_s, vs_d;
    logic [17:0] pd_m, pd_s;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            {cs_m, cs_s} <= 2'h3;
            // idle level of the serial clock, so no false edge after reset
            {scl_m, scl_s, scl_d} <= 3'h0;
            {sdi_m, sdi_s, id_m, id_s} <= 4'h0;
            {im_m, im_s} <= 8'h00;
            {pclk_m, pclk_s, pclk_d, pen_m, pen_s} <= 5'h00;
            {hs_m, hs_s, hs_d, vs_m, vs_s, vs_d} <= 6'h00;
            {pd_m, pd_s} <= 36'h0_0000_0000;
        end else begin
            {cs_m, cs_s} <= {CHIP_SELECT_N, cs_m};
            {scl_m, scl_s, scl_d} <= {SERIAL_CLOCK, scl_m, scl_s};
            {sdi_m, sdi_s} <= {SERIAL_IN, sdi_m};
            {id_m, id_s} <= {IDENTITY_STRAP_BIT, id_m};
            {im_m, im_s} <= {INTERFACE_MODE_STRAPS, im_m};
            {pclk_m, pclk_s, pclk_d} <= {PIXEL_CLOCK, pclk_m, pclk_s};
            {pen_m, pen_s} <= {PIXEL_ENABLE, pen_m};
            {hs_m, hs_s, hs_d} <= {LINE_SYNC, hs_m, hs_s};
            {vs_m, vs_s, vs_d} <= {FRAME_SYNC, vs_m, vs_s};
            {pd_m, pd_s} <= {PIXEL_DATA_PINS, pd_m};
        end
    end

    // ---------------- serial command port ----------------
    spi_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift, hi_byte, tx_shift, index, status_word;
    logic rs_bit, rw_bit, half;
    logic [2:0] rd_bytes;
    pix_width_t width;

    regfile_if rf ();
    reg_memory u_mem (
        .clk(CLK),
        .rst_n(rst_n),
        .port(rf.mem)
    );

    wire cs_active = !cs_s;
    wire scl_rise = cs_active && scl_s && !scl_d;
    wire scl_fall = cs_active && !scl_s && scl_d;
    wire [7:0] rx_byte = {rx_shift[6:0], sdi_s};
    wire byte_done = scl_rise && bit_cnt == 3'h7;
    wire strap_ok = im_s[3:1] == `STRAP_SPI_MODE;
    wire start_ok = strap_ok && rx_byte[7:3] == `START_PATTERN && rx_byte[2] == id_s;
    wire start_done = byte_done && state == ST_START;
    wire data_byte = byte_done && state == ST_DATA;
    wire word_done = data_byte && !rw_bit && half;
    wire idx_wr = word_done && !rs_bit;
    wire mem_wr = word_done && rs_bit;
    wire [15:0] word_in = {hi_byte, rx_byte};
    wire width_wr = mem_wr && index == `IDX_RGB_CTRL;
    wire [1:0] width_in = word_in[`RGB_WIDTH_MSB:`RGB_WIDTH_LSB];
    // status reads return the software status byte in the upper half
    wire [15:0] read_word = rs_bit ? rf.rdata : {status_word, 8'h00};
    wire in_dummy = rd_bytes < `DUMMY_READ_BYTES;
    wire [7:0] tx_next = in_dummy ? 8'h00 : (half ? read_word[7:0] : read_word[15:8]);
    wire read_start = start_done && start_ok && rx_byte[0];
    wire tx_load = read_start || (data_byte && rw_bit);

    assign rf.wr_en = mem_wr;
    assign rf.waddr = index;
    assign rf.wdata = word_in;
    assign rf.raddr = index;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_START;
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
        end else if (!cs_active) begin
            // partial bytes die with the frame
            state <= ST_START;
            bit_cnt <= 3'h0;
        end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= rx_byte;
            if (start_done) begin
                state <= start_ok ? ST_DATA : ST_IGNORE;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            {rs_bit, rw_bit, half} <= 3'h0;
            hi_byte <= 8'h00;
            rd_bytes <= 3'h0;
        end else if (!cs_active) begin
            half <= 1'b0;
            rd_bytes <= 3'h0;
        end else if (start_done && start_ok) begin
            rs_bit <= rx_byte[1];
            rw_bit <= rx_byte[0];
            half <= 1'b0;
            rd_bytes <= 3'h1;
        end else if (data_byte) begin
            if (!rw_bit && !half) begin
                hi_byte <= rx_byte;
            end
            if (!rw_bit || !in_dummy) begin
                half <= !half;
            end
            if (rw_bit && in_dummy) begin
                rd_bytes <= rd_bytes + 3'h1;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            index <= `INDEX_RESET;
            width <= pix_width_t'(`WIDTH_RESET);
        end else begin
            if (idx_wr) begin
                index <= word_in[7:0];
            end
            // prohibited width code is dropped, old setting kept
            if (width_wr && width_in != BUS_BAD) begin
                width <= pix_width_t'(width_in);
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift <= 8'h00;
            SERIAL_OUT <= 1'b0;
            SERIAL_OUT_EN <= 1'b0;
        end else if (!cs_active) begin
            SERIAL_OUT_EN <= 1'b0;
            SERIAL_OUT <= 1'b0;
        end else if (tx_load) begin
            tx_shift <= tx_next;
            if (read_start) begin
                SERIAL_OUT_EN <= 1'b1;
            end
        end else if (scl_fall && SERIAL_OUT_EN) begin
            SERIAL_OUT <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // ---------------- RGB pixel capture ----------------
    // pins are synchronised bit by bit; safe because data is held
    // well around the dot clock edge, so all bits settle together
    logic [1:0] phase;
    logic [11:0] partial;
    logic [8:0] line_count;
    wire pix_rise = pclk_s && !pclk_d;
    wire pix_take = pix_rise && pen_s;
    wire line_start = hs_s && !hs_d;
    wire frame_start = vs_s && !vs_d;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PIXEL_WORD <= 18'h0_0000;
            PIXEL_VALID <= 1'b0;
            phase <= 2'h0;
            partial <= 12'h000;
        end else begin
            PIXEL_VALID <= 1'b0;
            if (line_start || frame_start) begin
                phase <= 2'h0;
            end else if (pix_take) begin
                case (width)
                    BUS_W18: begin
                        PIXEL_WORD <= pd_s;
                        PIXEL_VALID <= 1'b1;
                    end
                    BUS_W16: begin
                        PIXEL_WORD <= widen16(pd_s);
                        PIXEL_VALID <= 1'b1;
                    end
                    BUS_W6: begin
                        // three transfers of six bits, first one is red
                        if (phase == 2'h2) begin
                            PIXEL_WORD <= {partial, pd_s[17:12]};
                            PIXEL_VALID <= 1'b1;
                            phase <= 2'h0;
                        end else begin
                            partial <= {partial[5:0], pd_s[17:12]};
                            phase <= phase + 2'h1;
                        end
                    end
                    default: begin
                        phase <= 2'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            line_count <= 9'h000;
        end else if (frame_start) begin
            line_count <= 9'h000;
        end else if (line_start) begin
            line_count <= line_count + 9'h001;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PIXEL_BUS_WIDTH_SEL <= pix_width_t'(`WIDTH_RESET);
        end else begin
            PIXEL_BUS_WIDTH_SEL <= width;
        end
    end

    // parallel mode: strobe low opens a write, bus word taken as it ends
    logic [17:0] par_word;
    wire par_wr = !strap_ok && scl_rise;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            par_word <= 18'h0_0000;
        end else if (par_wr) begin
            par_word <= pd_s;
        end
    end

    // ---------------- local register port ----------------
    wire [31:0] rd_mux =
        (REG_ADDR == `REG_STATUS_WORD) ? {24'h00_0000, status_word} :
        (REG_ADDR == `REG_PORT_INFO) ? {19'h0_0000, strap_ok, state, width, index} :
        (REG_ADDR == `REG_PIXEL) ? {14'h0000, PIXEL_WORD} :
        (REG_ADDR == `REG_LINE_COUNT) ? {23'h00_0000, line_count} :
        (REG_ADDR == `REG_PAR_WORD) ? {14'h0000, par_word} : 32'h0000_0000;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            status_word <= `STATUS_RESET;
            REG_RDATA <= 32'h0000_0000;
        end else begin
            if (REG_WR && REG_ADDR == `REG_STATUS_WORD) begin
                status_word <= REG_WDATA[7:0];
            end
            REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------- checks ----------------
    property p_idle_clears;
        @(posedge CLK) disable iff (!rst_n)
        $rose(cs_s) |=> (bit_cnt == 3'h0 && state == ST_START);
    endproperty
    a_idle_clears: assert property (p_idle_clears) else $error("frame end did not reset");

    property p_no_clock_outside;
        @(posedge CLK) disable iff (!rst_n)
        cs_s && $past(cs_s) && $past(cs_s, 2) |-> $stable(bit_cnt) && !rf.wr_en;
    endproperty
    a_no_clock_outside: assert property (p_no_clock_outside) else $error("clock used while idle");

    property p_ignore_no_write;
        @(posedge CLK) disable iff (!rst_n)
        state == ST_IGNORE |-> !rf.wr_en && !idx_wr && !SERIAL_OUT_EN;
    endproperty
    a_ignore_no_write: assert property (p_ignore_no_write) else $error("data taken after bad start");

    property p_id_mismatch;
        @(posedge CLK) disable iff (!rst_n)
        start_done && rx_byte[2] != id_s |=> state == ST_IGNORE;
    endproperty
    a_id_mismatch: assert property (p_id_mismatch) else $error("identity mismatch accepted");

    property p_write_only_rw0;
        @(posedge CLK) disable iff (!rst_n)
        rf.wr_en |-> !rw_bit && rs_bit && state == ST_DATA;
    endproperty
    a_write_only_rw0: assert property (p_write_only_rw0) else $error("write during read");

    property p_index_load;
        @(posedge CLK) disable iff (!rst_n)
        idx_wr |=> index == $past(rx_byte);
    endproperty
    a_index_load: assert property (p_index_load) else $error("index low byte wrong");

    property p_dummy_bytes;
        @(posedge CLK) disable iff (!rst_n)
        tx_load && in_dummy |=> tx_shift == 8'h00;
    endproperty
    a_dummy_bytes: assert property (p_dummy_bytes) else $error("dummy byte not zero");

    property p_width_legal;
        @(posedge CLK) disable iff (!rst_n)
        width_wr && width_in != BUS_BAD |=> ##1 PIXEL_BUS_WIDTH_SEL == $past(width_in, 2);
    endproperty
    a_width_legal: assert property (p_width_legal) else $error("width not applied");

    property p_out_on_fall;
        @(posedge CLK) disable iff (!rst_n)
        cs_active && $past(cs_active) && $changed(SERIAL_OUT) |-> $past(scl_fall);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");
endmodule // lcd_host_port
`default_nettype wire

/* File: host_model.sv */
// host model driving serial frames and the pixel bus toward the port
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic ser_out,
    output logic cs_n,
    output logic scl,
    output logic ser_in,
    output logic pclk,
    output logic pen,
    output logic lsync,
    output logic fsync,
    output logic [17:0] pdata
);
    logic [7:0] rx [0:7];
    initial begin
        cs_n = 1'b1;
        scl = 1'b0;
        ser_in = 1'b0;
        pclk = 1'b0;
        pen = 1'b0;
        lsync = 1'b0;
        fsync = 1'b0;
        pdata = 18'h0_0000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves mid low phase so it stays steady past the synced rise
    task automatic shift(input logic [7:0] b, input int nb, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            tick(2);
            ser_in <= b[i];
            tick(2);
            @(negedge clk);
            r[i] = ser_out;
            @(posedge clk);
            scl <= 1'b1;
            tick(3);
            scl <= 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] st, input logic [63:0] tx, input int n,
        input int cut);
        logic [7:0] r;
        @(posedge clk);
        cs_n <= 1'b0;
        shift(st, 8, r);
        for (int k = 0; k < n; k++) begin
            shift(tx[63-8*k -: 8], (k == n - 1) ? cut : 8, r);
            rx[k] = r;
        end
        tick(2);
        cs_n <= 1'b1;
        ser_in <= ~ser_in;
        tick(6);
    endtask
    task automatic pix(input logic [17:0] d, input logic en);
        @(posedge clk);
        pclk <= 1'b0;
        pdata <= d;
        pen <= en;
        tick(4);
        pclk <= 1'b1;
        tick(4);
    endtask
    task automatic sync(input logic frm);
        @(posedge clk);
        if (frm) begin
            fsync <= 1'b1;
        end else begin
            lsync <= 1'b1;
        end
        tick(4);
        fsync <= 1'b0;
        lsync <= 1'b0;
        tick(4);
    endtask
endmodule // host_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the serial command port and pixel capture
`include "lcd_port_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import lcd_port_pkg::*;
    typedef struct packed {
        logic [1:0] code;
        logic [1:0] n;
        logic [17:0] p0;
        logic [17:0] p1;
        logic [17:0] p2;
        logic [17:0] exp;
    } row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic id_strap = 1'b1;
    logic [3:0] straps = 4'h5;
    logic [3:0] raddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic cs_n, scl, ser_in, ser_out, ser_oe, pclk, pen, lsync, fsync, pvalid;
    int n_oe = 0;
    logic [17:0] pdata, pword;
    logic [17:0] got = 18'h0_0000;
    logic [31:0] rdata, d;
    pix_width_t width;
    int errors = 0;
    int tests_run = 0;
    int nvalid = 0;
    int cycles = 0;
    int v0;
    logic [7:0] bad_st [0:3];
    logic [3:0] bad_im [0:3] = '{4'h5, 4'h5, 4'h6, 4'h4};
    row_t rows [0:2] = '{
        '{2'b00, 2'h1, 18'h2_A5C3, 18'h0_0000, 18'h0_0000, 18'h2_A5C3},
        '{2'b01, 2'h1, 18'h2_AAAA, 18'h0_0000, 18'h0_0000, 18'h2_BAAB},
        '{2'b10, 2'h3, 18'h1_5000, 18'h2_AFFF, 18'h3_3000, 18'h1_5AB3}
    };
    lcd_host_port DUT (.CLK(clk), .RESETN(resetn), .CHIP_SELECT_N(cs_n),
        .SERIAL_CLOCK(scl), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out),
        .SERIAL_OUT_EN(ser_oe), .INTERFACE_MODE_STRAPS(straps),
        .IDENTITY_STRAP_BIT(id_strap), .PIXEL_CLOCK(pclk), .PIXEL_ENABLE(pen),
        .LINE_SYNC(lsync), .FRAME_SYNC(fsync), .PIXEL_DATA_PINS(pdata),
        .PIXEL_WORD(pword), .PIXEL_VALID(pvalid), .PIXEL_BUS_WIDTH_SEL(width),
        .REG_ADDR(raddr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata));
    host_model HOST (.clk(clk), .ser_out(ser_out), .cs_n(cs_n), .scl(scl),
        .ser_in(ser_in), .pclk(pclk), .pen(pen), .lsync(lsync), .fsync(fsync),
        .pdata(pdata));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (pvalid === 1'b1) begin
            nvalid <= nvalid + 1;
            got <= pword;
        end
        if (ser_oe === 1'b1) begin
            n_oe <= n_oe + 1;
        end
    end
    // ceiling is several times the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic rwr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        raddr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rrd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        raddr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    function automatic logic [7:0] st(input logic sel, input logic rw);
        return {`START_PATTERN, id_strap, sel, rw};
    endfunction
    task automatic wreg(input logic [7:0] idx, input logic [15:0] w);
        HOST.frame(st(1'b0, 1'b0), {8'h00, idx, 48'h0}, 2, 8);
        HOST.frame(st(1'b1, 1'b0), {w, 48'h0}, 2, 8);
    endtask
    task automatic settle;
        HOST.tick(4);
        @(negedge clk);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        settle();
        chk({30'h0, width}, 32'h0000_0000);
        chk({31'h0, ser_oe}, 32'h0000_0000);
        chk(rdata, 32'h0000_0000);
        done("reset");
        foreach (rows[i]) begin
            wreg(8'h0C, {14'h1A5C, rows[i].code});
            settle();
            chk({30'h0, width}, {30'h0, rows[i].code});
            rrd(4'h1, d);
            chk(d & 32'h0000_03FF, {22'h0, rows[i].code, 8'h0C});
            HOST.sync(1'b0);
            v0 = nvalid;
            HOST.pix(rows[i].p0, 1'b1);
            if (rows[i].n == 2'h3) begin
                HOST.pix(rows[i].p1, 1'b1);
                HOST.pix(rows[i].p2, 1'b1);
            end
            settle();
            chk(nvalid - v0, 32'h0000_0001);
            chk({14'h0, got}, {14'h0, rows[i].exp});
            done("width row");
        end
        v0 = n_oe;
        HOST.frame(st(1'b1, 1'b1), 64'h0, 7, 8);
        chk({24'h0, HOST.rx[0]}, 32'h0000_0000);
        chk({HOST.rx[1], HOST.rx[2], HOST.rx[3], HOST.rx[4]}, 32'h0000_0000);
        chk({16'h0, HOST.rx[5], HOST.rx[6]}, 32'h0000_6972);
        chk({31'h0, n_oe > v0}, 32'h0000_0001);
        chk({31'h0, ser_oe}, 32'h0000_0000);
        rwr(4'h0, 32'h0000_00A5);
        rrd(4'h0, d);
        chk(d, 32'h0000_00A5);
        HOST.frame(st(1'b0, 1'b1), 64'h0, 7, 8);
        chk({16'h0, HOST.rx[5], HOST.rx[6]}, 32'h0000_A500);
        done("serial read");
        bad_st = '{8'h7E, {`START_PATTERN, ~id_strap, 2'b10}, st(1'b1, 1'b0),
            st(1'b1, 1'b0)};
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            straps <= bad_im[k];
            HOST.frame(bad_st[k], {(k == 3) ? 16'h6973 : 16'h6971, 48'h0}, 2, 8);
            settle();
            chk({30'h0, width}, 32'h0000_0002);
        end
        @(posedge clk);
        straps <= 4'h5;
        done("refused frames");
        HOST.frame(st(1'b0, 1'b0), {16'h0055, 48'h0}, 2, 4);
        rrd(4'h1, d);
        chk(d & 32'h0000_00FF, 32'h0000_000C);
        HOST.frame(st(1'b0, 1'b0), {16'h0033, 48'h0}, 2, 8);
        rrd(4'h1, d);
        chk(d & 32'h0000_00FF, 32'h0000_0033);
        done("abort");
        v0 = nvalid;
        HOST.pix(18'h3_F000, 1'b1);
        HOST.sync(1'b1);
        HOST.pix(18'h0_1000, 1'b1);
        HOST.pix(18'h0_2000, 1'b1);
        HOST.pix(18'h3_F000, 1'b0);
        HOST.pix(18'h0_3000, 1'b1);
        settle();
        chk(nvalid - v0, 32'h0000_0001);
        chk({14'h0, got}, 32'h0000_1083);
        rrd(4'hF, d);
        chk(d, 32'h0000_0000);
        rwr(4'h2, 32'h0003_FFFF);
        rrd(4'h2, d);
        chk(d, 32'h0000_1083);
        HOST.sync(1'b0);
        HOST.sync(1'b0);
        rrd(4'h3, d);
        chk(d, 32'h0000_0002);
        HOST.pix(18'h2_5A5A, 1'b0);
        @(posedge clk);
        straps <= 4'h0;
        HOST.frame(8'hFF, 64'h0, 0, 8);
        rrd(4'h4, d);
        chk(d, 32'h0002_5A5A);
        @(posedge clk);
        straps <= 4'h5;
        HOST.pix(18'h0_0001, 1'b0);
        HOST.frame(st(1'b0, 1'b0), {16'h000C, 48'h0}, 2, 8);
        rrd(4'h4, d);
        chk(d, 32'h0002_5A5A);
        done("phase and register port");
        @(posedge clk);
        resetn <= 1'b0;
        settle();
        chk({30'h0, width}, 32'h0000_0000);
        @(posedge clk);
        resetn <= 1'b1;
        settle();
        rrd(4'h0, d);
        chk(d, 32'h0000_0000);
        done("second reset");
        results();
    end
endmodule // tb_top
`default_nettype wire
